// File: hdl/bsst_defs.vh
`ifndef BSST_DEFS_VH
`define BSST_DEFS_VH
// register byte offsets
`define BSST_STATUS_OFS    12'h000
`define BSST_START_OFS     12'h004
`define BSST_END_OFS       12'h008
`define BSST_FUNC_OFS      12'h00c
`define BSST_DRIVE_OFS     12'h010
`define BSST_CLKGAP_OFS    12'h014
`define BSST_IRQ_OFS       12'h018
`define BSST_BUF_OFS       12'h080
// status register fields
`define BSST_ST_BUSY       0
`define BSST_ST_ABORT      1
`define BSST_ST_WAIT       2
`define BSST_ST_OVRN       3
`define BSST_ST_LEVEL      4
`define BSST_ST_RESV       3'b111
// function select fields
`define BSST_FN_SO         0
`define BSST_FN_SI         1
`define BSST_FN_SCK        2
`define BSST_FN_CS         3
// clock/gap control fields
`define BSST_CG_EXT        0
`define BSST_CG_DIV_LSB    4
// gap field sits above the divider so the two never overlap
`define BSST_CG_GAP_LSB    12
// clock/gap reset value, buffer read value while busy, buffer index width
`define BSST_CLKGAP_RST    32'h0000_0000
`define BSST_BUF_FILL      8'hff
`define BSST_ADDR_W        5
`endif

// File: hdl/bsst_sync.v
`timescale 1ns/100ps
`default_nettype none
module bsst_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= {W{1'b0}};
            q      <= {W{1'b0}};
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// File: hdl/bsst_top.v
`timescale 1ns/100ps
`default_nettype none
`include "bsst_defs.vh"
module bsst_top #(
    parameter DEPTH = 32
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        serial_clock_pin_i,
    output reg         serial_clock_pin_o,
    output reg         serial_clock_pin_oe,
    input  wire        serial_in_pin,
    output reg         serial_out_pin_o,
    output reg         serial_out_pin_oe,
    input  wire        select_n_pin
);
    localparam ST_IDLE = 2'd0;
    localparam ST_WAIT = 2'd1;
    localparam ST_RUN  = 2'd2;
    localparam ST_GAP  = 2'd3;

    reg  [7:0] buf_mem [0:DEPTH-1];
    reg  [1:0] state_q;
    reg  [4:0] start_q;
    reg  [4:0] end_q;
    reg  [3:0] func_q;
    reg        od_q;
    reg        ext_q;
    reg  [7:0] div_q;
    reg  [1:0] gap_q;
    reg        abort_flag_q;
    reg        wait_flag_q;
    reg        overrun_flag_q;
    reg        level_q;
    reg        irq_q;
    reg        float_q;
    reg  [4:0] ptr_q;
    reg  [7:0] sh_q;
    reg  [2:0] bit_q;
    reg  [7:0] divc_q;
    reg  [4:0] gapc_q;
    reg        isck_q;
    reg        sck_prev_q;
    wire [1:0] pins_s;
    wire       sck_s = pins_s[0];
    wire       cs_n_s = pins_s[1];
    reg        si_q;

    bsst_sync #(.W(2)) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({select_n_pin, serial_clock_pin_i}),
        .q     (pins_s)
    );

    // data in passes two flops as well: with the internal clock the
    // divider must be 3 or more, or a rising edge samples a stale bit
    reg si_m_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            si_m_q <= 1'b0;
            si_q   <= 1'b0;
        end else begin
            si_m_q <= serial_in_pin;
            si_q   <= si_m_q;
        end
    end

    function [4:0] next_ptr;
        input [4:0] p;
        begin
            next_ptr = (p == DEPTH - 1) ? 5'd0 : p + 5'd1;
        end
    endfunction

    wire busy    = (state_q != ST_IDLE);
    wire cs_en   = func_q[`BSST_FN_CS];
    wire acc     = psel && !penable;
    wire wr      = acc && pwrite;
    wire rd      = acc && !pwrite;
    wire buf_hit = paddr[11:7] == `BSST_BUF_OFS >> 7;
    wire [4:0] buf_idx = paddr[6:2];

    // serial clock edges: internal divider or synchronised pin
    wire div_tick = (divc_q == div_q);
    wire int_fall = !ext_q && state_q == ST_RUN && div_tick && isck_q;
    wire int_rise = !ext_q && state_q == ST_RUN && div_tick && !isck_q;
    wire ext_fall = ext_q && sck_prev_q && !sck_s;
    wire ext_rise = ext_q && !sck_prev_q && sck_s;
    wire do_fall  = ext_q ? (ext_fall && state_q == ST_RUN) : int_fall;
    wire do_rise  = ext_q ? (ext_rise && state_q == ST_RUN) : int_rise;
    wire last_bit = (bit_q == 3'd7);
    wire last_byte = (ptr_q == end_q);
    wire [7:0] rx_byte = {si_q, sh_q[7:1]};

    wire st_wr   = wr && paddr == `BSST_STATUS_OFS;
    // clearing busy mid-transfer stops it without an irq request
    wire sw_stop = st_wr && busy
                   && !pwdata[`BSST_ST_BUSY];
    // the abort flag is sampled before this write clears it, so a
    // single write cannot both clear the flag and start
    wire sw_go   = st_wr && !busy
                   && pwdata[`BSST_ST_BUSY] && !abort_flag_q;
    wire abort   = cs_en && cs_n_s && (state_q == ST_RUN
                   || state_q == ST_GAP);
    wire overrun = ext_q && ext_rise && state_q == ST_IDLE
                   && !(cs_en && cs_n_s);
    wire buf_blk = acc && buf_hit && busy;

    always @(posedge pclk) begin
        if (wr && buf_hit && !busy)
            buf_mem[buf_idx] <= pwdata[7:0];
        else if (do_rise && last_bit && func_q[`BSST_FN_SI])
            buf_mem[ptr_q] <= rx_byte;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= ST_IDLE;
            start_q    <= 5'd0;
            end_q      <= 5'd0;
            func_q     <= 4'd0;
            od_q       <= 1'b0;
            ext_q      <= 1'b0;
            div_q      <= 8'd0;
            gap_q      <= 2'd0;
            abort_flag_q   <= 1'b0;
            wait_flag_q    <= 1'b0;
            overrun_flag_q <= 1'b0;
            level_q        <= 1'b0;
            irq_q      <= 1'b0;
            float_q    <= 1'b0;
            ptr_q      <= 5'd0;
            sh_q       <= 8'd0;
            bit_q      <= 3'd0;
            divc_q     <= 8'd0;
            gapc_q     <= 5'd0;
            isck_q     <= 1'b1;
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= sck_s;
            if (wr && !busy) begin
                case (paddr)
                    `BSST_START_OFS: start_q <= pwdata[4:0];
                    `BSST_END_OFS:   end_q   <= pwdata[4:0];
                    `BSST_FUNC_OFS:  func_q  <= pwdata[3:0];
                    `BSST_DRIVE_OFS: od_q    <= pwdata[0];
                    `BSST_CLKGAP_OFS: begin
                        ext_q <= pwdata[`BSST_CG_EXT];
                        div_q <= pwdata[`BSST_CG_DIV_LSB +: 8];
                        gap_q <= pwdata[`BSST_CG_GAP_LSB +: 2];
                    end
                    default: ;
                endcase
            end
            if (st_wr) begin
                // flags clear on a written zero
                if (!pwdata[`BSST_ST_ABORT])
                    abort_flag_q <= 1'b0;
                if (!pwdata[`BSST_ST_WAIT])
                    wait_flag_q <= 1'b0;
                if (!pwdata[`BSST_ST_OVRN])
                    overrun_flag_q <= 1'b0;
                // a level write while idle also takes the pins back
                if (!busy) begin
                    level_q <= pwdata[`BSST_ST_LEVEL];
                    float_q <= 1'b0;
                end
            end
            if (wr && paddr == `BSST_IRQ_OFS && !pwdata[0])
                irq_q <= 1'b0;
            // flag sets placed after clears so a set wins
            if (buf_blk)
                wait_flag_q <= 1'b1;
            if (overrun)
                overrun_flag_q <= 1'b1;
            divc_q <= div_tick ? 8'd0 : divc_q + 8'd1;

            case (state_q)
                ST_IDLE: begin
                    isck_q <= 1'b1;
                    if (sw_go) begin
                        ptr_q  <= start_q;
                        bit_q  <= 3'd0;
                        divc_q <= 8'd0;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (sw_stop) begin
                        state_q <= ST_IDLE;
                    end else if (!cs_en || !cs_n_s) begin
                        sh_q    <= buf_mem[ptr_q];
                        level_q <= buf_mem[ptr_q][0];
                        float_q <= 1'b0;
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (int_fall || int_rise)
                        isck_q <= ~isck_q;
                    if (do_fall && bit_q != 3'd0)
                        level_q <= sh_q[0];
                    if (do_rise) begin
                        sh_q  <= rx_byte;
                        bit_q <= bit_q + 3'd1;
                        if (last_bit) begin
                            if (last_byte) begin
                                irq_q   <= 1'b1;
                                state_q <= ST_IDLE;
                            end else begin
                                ptr_q  <= next_ptr(ptr_q);
                                gapc_q <= {gap_q, 3'b000};
                                state_q <= ST_GAP;
                            end
                        end
                    end
                    if (sw_stop) state_q <= ST_IDLE;
                end
                ST_GAP: begin
                    // clock stays high through the gap
                    // the next byte loads whole, like the first one, so
                    // the first fall of each byte keeps bit 0 up
                    if (gapc_q == 5'd0 || ext_q) begin
                        sh_q    <= buf_mem[ptr_q];
                        level_q <= buf_mem[ptr_q][0];
                        state_q <= ST_RUN;
                    end else if (div_tick) begin
                        gapc_q <= gapc_q - 5'd1;
                    end
                    if (sw_stop) state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
            if (abort) begin
                abort_flag_q <= 1'b1;
                irq_q   <= 1'b1;
                float_q <= 1'b1;
                isck_q  <= 1'b1;
                state_q <= ST_IDLE;
            end
        end
    end

    // sh_q[0] is the bit that the next falling edge puts out
    // pins are registered once more so every output is a flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_clock_pin_o  <= 1'b1;
            serial_clock_pin_oe <= 1'b0;
            serial_out_pin_o    <= 1'b0;
            serial_out_pin_oe   <= 1'b0;
        end else begin
            serial_clock_pin_o  <= isck_q;
            serial_clock_pin_oe <= func_q[`BSST_FN_SCK] && !ext_q
                                   && !float_q;
            // open drain releases the line for a one
            serial_out_pin_o    <= od_q ? 1'b0 : level_q;
            serial_out_pin_oe   <= func_q[`BSST_FN_SO] && !float_q
                                   && !(od_q && level_q);
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc;
            pslverr <= 1'b0;
            if (rd) begin
                case (paddr)
                    `BSST_STATUS_OFS: prdata <= {24'h0, `BSST_ST_RESV,
                        level_q, overrun_flag_q, wait_flag_q,
                        abort_flag_q, busy};
                    `BSST_START_OFS:  prdata <= {27'h0, start_q};
                    `BSST_END_OFS:    prdata <= {27'h0, end_q};
                    `BSST_FUNC_OFS:   prdata <= {28'h0, func_q};
                    `BSST_DRIVE_OFS:  prdata <= {31'h0, od_q};
                    `BSST_CLKGAP_OFS: prdata <= {18'h0, gap_q, div_q,
                        3'b000, ext_q};
                    `BSST_IRQ_OFS:    prdata <= {31'h0, irq_q};
                    default: begin
                        if (buf_hit)
                            prdata <= {24'h0, busy ? `BSST_BUF_FILL
                                       : buf_mem[buf_idx]};
                        else
                            prdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: verification/bsst_chk_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "bsst_defs.vh"
module bsst_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        serial_clock_pin_o,
    input wire logic        serial_clock_pin_oe,
    input wire logic        serial_out_pin_o
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd_setup;
    assign rd_setup = psel && !penable && !pwrite;
    chk_pready_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    chk_pready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_slverr_low: assert property (!pslverr)
        else $error("pslverr raised");
    chk_unmapped_zero: assert property (rd_setup && paddr >= 12'h01c
        && paddr < 12'h080 |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    chk_resv_ones: assert property (rd_setup && paddr == `BSST_STATUS_OFS
        |=> prdata[7:5] == `BSST_ST_RESV)
        else $error("reserved status bits not ones");
    chk_rdata_hold: assert property (!rd_setup |=> $stable(prdata))
        else $error("read data moved without a read");
    chk_data_fall: assert property (
        serial_clock_pin_oe && $past(serial_clock_pin_oe)
        && $rose(serial_clock_pin_o) |-> $stable(serial_out_pin_o))
        else $error("serial out changed on rising clock");
    chk_clk_driven: assert property (
        $changed(serial_clock_pin_o)
        |-> serial_clock_pin_oe || $past(serial_clock_pin_oe))
        else $error("clock toggled while not driven");
    cover property (psel && penable && pready && !pwrite);
    cover property ($rose(serial_clock_pin_oe));
    cover property ($fell(serial_clock_pin_oe));
endmodule
bind bsst_top bsst_chk bsst_chk_inst (.*);
`default_nettype wire

// File: verification/bsst_peer.sv
`timescale 1ns/100ps
`default_nettype none
module bsst_peer (
    input  wire logic       sck,
    input  wire logic       mosi,
    output logic            sck_ext,
    output logic            miso,
    output logic [7:0]      rx_byte
);
    logic [7:0] tx_q;
    initial begin
        sck_ext = 1'b1;
        miso = 1'b0;
        tx_q = 8'h3c;
        rx_byte = 8'h00;
    end
    // rotating keeps every byte equal once realigned by the bench
    always @(negedge sck) begin
        miso <= tx_q[0];
        tx_q <= {tx_q[0], tx_q[7:1]};
    end
    always @(posedge sck) begin
        rx_byte <= {mosi, rx_byte[7:1]};
    end
    // clock only runs inside a burst, idle high as sck_ext rests at one
    task burst(input int n);
        #10;
        repeat (n) begin
            #160 sck_ext = 1'b0;
            #160 sck_ext = 1'b1;
        end
    endtask
endmodule
`default_nettype wire

// File: verification/tb_buffered_sync_serial_transfer.sv
`timescale 1ns/100ps
`default_nettype none
`include "bsst_defs.vh"
module tb_buffered_sync_serial_transfer;
    localparam logic [11:0] ST = `BSST_STATUS_OFS;
    localparam logic [11:0] SA = `BSST_START_OFS;
    localparam logic [11:0] EA = `BSST_END_OFS;
    localparam logic [11:0] FN = `BSST_FUNC_OFS;
    localparam logic [11:0] CG = `BSST_CLKGAP_OFS;
    localparam logic [11:0] DR = `BSST_DRIVE_OFS;
    localparam logic [11:0] IQ = `BSST_IRQ_OFS;
    localparam logic [11:0] BF = `BSST_BUF_OFS;
    logic        pclk, presetn, psel, penable, pwrite, select_n_pin;
    logic [11:0] paddr;
    logic [31:0] pwdata, rv, seed;
    logic [7:0]  mem [32];
    wire  [31:0] prdata;
    wire         pready, pslverr, serial_clock_pin_o, serial_clock_pin_oe;
    wire         serial_out_pin_o, serial_out_pin_oe, serial_in_pin;
    wire         peer_sck, sck_w;
    wire  [7:0]  peer_rx;
    int          error_cnt, checked;
    assign sck_w = serial_clock_pin_oe ? serial_clock_pin_o : peer_sck;
    bsst_top bsst_top_inst (.*, .serial_clock_pin_i(sck_w));
    bsst_peer bsst_peer_inst (.sck(sck_w), .sck_ext(peer_sck),
        .mosi(serial_out_pin_oe ? serial_out_pin_o : 1'b1),
        .miso(serial_in_pin), .rx_byte(peer_rx));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        #3000000;
        error_cnt++;
        final_report;
    end
    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task cmp(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, g, x);
        end
    endtask
    task apb(input int w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= (w != 0);
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        cmp(pready, 1'b1);
        rv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task idle;
        int n;
        n = 0;
        do begin
            apb(0, ST, 0);
            n++;
        end while (rv[0] !== 1'b0 && n < 2000);
    endtask
    task run(input logic [3:0] fn, input logic [31:0] cg,
             input logic [4:0] s, input logic [4:0] e, input int nx);
        logic [4:0] p;
        logic [7:0] lb;
        p = s;
        forever begin
            lb = mem[p];
            if (fn[1]) mem[p] = 8'h3c;
            if (p == e) break;
            p++;
        end
        bsst_peer_inst.tx_q = 8'h3c;
        apb(1, FN, {28'h0, fn});
        apb(1, CG, cg);
        apb(1, SA, {seed[31:5], s});
        apb(1, EA, {seed[26:0], e});
        apb(1, ST, 1);
        apb(0, BF + {5'h0, s, 2'b00}, 0);
        cmp(rv[7:0], 8'hff);
        apb(1, BF, 0);
        if (nx > 0) bsst_peer_inst.burst(nx);
        idle;
        cmp(rv[3:0], 4'b0100);
        cmp(serial_out_pin_o, lb[7]);
        apb(0, IQ, 0);
        cmp(rv[0], 1'b1);
        apb(1, ST, {27'h0, lb[7], 4'h0});
        apb(1, IQ, 0);
        for (int i = 0; i < 32; i++) begin
            apb(0, BF + {5'h0, i[4:0], 2'b00}, 0);
            cmp(rv[7:0], mem[i]);
        end
        cmp(peer_rx, lb);
    endtask
    task final_report;
        $display("checked=%0d error_cnt=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        select_n_pin = 1'b1;
        seed = 32'ha6f3;
        error_cnt = 0;
        checked = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, ST, 0);
        cmp(rv[7:0], 8'he0);
        apb(0, 12'h040, 0);
        cmp(rv, 32'h0);
        for (int i = 0; i < 32; i++) begin
            seed = lfsr(seed);
            mem[i] = seed[7:0];
            apb(1, BF + {5'h0, i[4:0], 2'b00}, seed);
        end
        // select held high first: start must wait, then abort mid-byte
        apb(1, FN, 32'hf);
        apb(1, CG, 32'h30);
        apb(1, ST, 1);
        repeat (10) @(posedge pclk);
        apb(0, ST, 0);
        cmp(rv[0], 1'b1);
        select_n_pin <= 1'b0;
        repeat (12) @(posedge pclk);
        select_n_pin <= 1'b1;
        idle;
        cmp(rv[1:0], 2'b10);
        cmp({serial_clock_pin_oe, serial_out_pin_oe}, 2'b00);
        apb(0, IQ, 0);
        cmp(rv[0], 1'b1);
        apb(1, ST, 1);
        apb(0, ST, 0);
        cmp(rv[0], 1'b0);
        apb(1, ST, 0);
        apb(1, IQ, 0);
        seed = lfsr(seed);
        run(4'h7, 32'h1030, seed[4:0], seed[9:5], 0);
        run(4'h7, 32'h40, 5'd3, 5'd3, 0);
        run(4'h5, 32'h30, 5'd30, 5'd1, 0);
        run(4'h7, 32'h1, 5'd9, 5'd9, 8);
        bsst_peer_inst.burst(1);
        repeat (4) @(posedge pclk);
        apb(0, ST, 0);
        cmp(rv[3], 1'b1);
        apb(1, ST, 32'h10);
        cmp(serial_out_pin_o, 1'b1);
        apb(1, ST, 0);
        cmp(serial_out_pin_o, 1'b0);
        apb(1, DR, 1);
        apb(1, ST, 32'h10);
        cmp({serial_out_pin_oe, serial_out_pin_o}, 2'b00);
        apb(1, ST, 0);
        cmp({serial_out_pin_oe, serial_out_pin_o}, 2'b10);
        final_report;
    end
endmodule
`default_nettype wire
